// ---- design/eeps_pkg.sv ----
// constants and types shared by the two-wire memory slave
// assumes a 25 MHz core clock sampling both bus pins
package eeps_pkg;

    // ------------------------------------------------------------
    // clock and self-timed programming
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int PROG_TIME_US  = 5000;  // program_cycle_time, plain default
    localparam int PROG_CYCLES   = (PROG_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int PROG_CNT_W    = 24;

    // ------------------------------------------------------------
    // array geometry and byte framing
    // ------------------------------------------------------------
    localparam int ADDR_W     = 11;
    localparam int DEPTH      = 2048;
    localparam int PAGE_W     = 4;
    localparam int PAGE_BYTES = 16;
    localparam int HI_W       = 3;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_ONE  = 4'h1;
    localparam logic [3:0] BIT_NONE = 4'h0;

    // ------------------------------------------------------------
    // slave address fields
    // ------------------------------------------------------------
    localparam int TYPE_MSB = 7;
    localparam int TYPE_LSB = 4;
    localparam int HI_MSB   = 3;
    localparam int HI_LSB   = 1;
    localparam int RW_BIT   = 0;

    // ------------------------------------------------------------
    // byte phases and slave states
    // ------------------------------------------------------------
    localparam logic [1:0] PH_SLV  = 2'h0;
    localparam logic [1:0] PH_WORD = 2'h1;
    localparam logic [1:0] PH_DATA = 2'h2;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_RX    = 7'h02,
        ST_ACK   = 7'h04,
        ST_TX    = 7'h08,
        ST_TXACK = 7'h10,
        ST_WAIT  = 7'h20,
        ST_PROG  = 7'h40
    } eeps_state_t;

endpackage

// ---- design/eeps_pin_sync.sv ----
// two-stage synchronisers for the bus pins plus one history stage
// assumes pins idle high; history stage gives edge detection
`timescale 1ns/100ps
module eeps_pin_sync (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rstn_i,
    // raw pins
    input  wire logic [1:0] pin_i,
    // synchronised level and its previous sample
    output logic      [1:0] sync_o,
    output logic      [1:0] prev_o
);
    logic [1:0] meta_q;

    // ------------------------------------------------------------
    // per pin: two flops, then history for edges
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++)
    begin : g_pin
        always_ff @(posedge core_clk_i or negedge rstn_i)
        begin
            if (!rstn_i)
            begin
                meta_q[i] <= 1'b1;
                sync_o[i] <= 1'b1;
                prev_o[i] <= 1'b1;
            end
            else
            begin
                meta_q[i] <= pin_i[i];
                sync_o[i] <= meta_q[i];  // only reader of meta_q
                prev_o[i] <= sync_o[i];
            end
        end
    end
endmodule

// ---- design/eeps_mem_array.sv ----
// flip-flop storage for the 2,048 x 8 array
// assumes one write per cycle from the programming sequencer
`timescale 1ns/100ps
module eeps_mem_array
    import eeps_pkg::*;
(
    // clock
    input  wire logic              core_clk_i,
    // write port
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] waddr_i,
    input  wire logic [7:0]        wdata_i,
    // read port, combinational
    input  wire logic [ADDR_W-1:0] raddr_i,
    output logic      [7:0]        rdata_o
);
    logic [7:0] mem_q [DEPTH];

    // storage has no reset, like a real array
    always_ff @(posedge core_clk_i)
    begin
        if (we_i)
            mem_q[waddr_i] <= wdata_i;
    end

    assign rdata_o = mem_q[raddr_i];
endmodule

// ---- design/eeps_slave.sv ----
// two-wire serial slave front end of a 2,048 x 8 nonvolatile memory
// assumes scl and sda pins come from the bus master, unsynchronised
`timescale 1ns/100ps
module eeps_slave
    import eeps_pkg::*;
#(
    parameter int         PROG_CYC = PROG_CYCLES,
    parameter logic [3:0] DEV_TYPE = 4'h6  // arbitrary type code
)
(
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    // serial bus pins
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe_o,
    // status
    output logic      prog_busy_o
);
    import eeps_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [1:0]            pin_s;
    logic [1:0]            pin_p;
    logic                  scl_s;
    logic                  sda_s;
    logic                  scl_p;
    logic                  sda_p;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  start_ev;
    logic                  stop_ev;
    logic                  byte_done;
    logic                  type_ok;
    logic                  load_tx;
    logic                  mem_we;
    logic [7:0]            mem_rdata;
    eeps_state_t           state_q;
    logic [3:0]            cnt_q;
    logic [1:0]            ph_q;
    logic                  rw_q;
    logic                  acked_q;
    logic [7:0]            rx_q;
    logic [7:0]            tx_q;
    logic [HI_W-1:0]       hi_q;
    logic [ADDR_W-1:0]     addr_q;
    logic [7:0]            page_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] valid_q;
    logic [PROG_CNT_W-1:0] prog_cnt_q;
    logic                  sda_oe_q;
    logic                  busy_q;

    // ------------------------------------------------------------
    // pin synchronisers and bus events
    // ------------------------------------------------------------
    eeps_pin_sync u_sync (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .pin_i      ({sda_i, scl_i}),
        .sync_o     (pin_s),
        .prev_o     (pin_p)
    );

    assign scl_s = pin_s[0];
    assign sda_s = pin_s[1];
    assign scl_p = pin_p[0];
    assign sda_p = pin_p[1];

    // edges of the master clock, plus start and stop as data edges while it is high; one bit per pulse
    // one bit per pulse
    assign scl_rise = scl_s & ~scl_p;
    assign scl_fall = ~scl_s & scl_p;
    assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_ev  = scl_s & scl_p & ~sda_p & sda_s;

    // byte complete on the fall after the eighth rise
    assign byte_done = (state_q == ST_RX) && scl_fall && (cnt_q == BIT_LAST);
    assign type_ok   = (rx_q[TYPE_MSB:TYPE_LSB] == DEV_TYPE);
    // next read byte is fetched on a fall, ack from master decides
    assign load_tx   = scl_fall && (((state_q == ST_ACK) && (ph_q == PH_SLV) && rw_q)
                                    || ((state_q == ST_TXACK) && acked_q));

    // ------------------------------------------------------------
    // main state machine, bit counter and byte phase
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= ST_IDLE;
            cnt_q   <= BIT_NONE;
            ph_q    <= PH_SLV;
            rw_q    <= 1'b0;
        end
        else if (start_ev && (state_q != ST_PROG))
        begin
            state_q <= ST_RX;
            cnt_q   <= BIT_NONE;
            ph_q    <= PH_SLV;
        end
        // stop after write data starts programming
        else if (stop_ev && (state_q != ST_PROG))
        begin
            state_q <= ((ph_q == PH_DATA) && (|valid_q)) ? ST_PROG : ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_RX:
                begin
                    if (scl_rise)
                        cnt_q <= cnt_q + BIT_ONE;
                    // ack only a matching slave address
                    if (byte_done)
                    begin
                        if ((ph_q == PH_SLV) && !type_ok)
                            state_q <= ST_IDLE;  // not ours, wait for next start
                        else
                            state_q <= ST_ACK;
                        if (ph_q == PH_SLV)
                            rw_q <= rx_q[RW_BIT];
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        if ((ph_q == PH_SLV) && rw_q)
                        begin
                            state_q <= ST_TX;
                            cnt_q   <= BIT_ONE;
                        end
                        else
                        begin
                            state_q <= ST_RX;
                            cnt_q   <= BIT_NONE;
                            ph_q    <= (ph_q == PH_SLV) ? PH_WORD : PH_DATA;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_q == BIT_LAST)
                            state_q <= ST_TXACK;
                        else
                            cnt_q <= cnt_q + BIT_ONE;
                    end
                end
                ST_TXACK:
                begin
                    if (scl_fall)
                    begin
                        state_q <= acked_q ? ST_TX : ST_WAIT;
                        cnt_q   <= BIT_ONE;
                    end
                end
                ST_PROG:
                begin
                    // leave only when programming is done
                    if (prog_cnt_q == PROG_CNT_W'(PROG_CYC - 1))
                        state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= state_q;  // idle and wait hold until start or stop
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // receive shift and master acknowledge sample
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_q    <= 8'h00;
            acked_q <= 1'b0;
        end
        else
        begin
            // sample only on rising scl, data stable while high
            if ((state_q == ST_RX) && scl_rise)
                rx_q <= {rx_q[6:0], sda_s};
            // low on ninth clock means master wants more
            if ((state_q == ST_TXACK) && scl_rise)
                acked_q <= ~sda_s;
        end
    end

    // ------------------------------------------------------------
    // address counter and high address bits
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hi_q   <= '0;
            addr_q <= '0;
        end
        else if (byte_done)
        begin
            // three high bits join the word address byte
            if (ph_q == PH_SLV)
                hi_q <= rx_q[HI_MSB:HI_LSB];
            else if (ph_q == PH_WORD)
                addr_q <= {hi_q, rx_q};
            // only the in-page bits advance; wraps
            else
                addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 4'h1;
        end
        // whole counter advances per read byte
        else if (load_tx)
            addr_q <= addr_q + 11'h001;
    end

    // ------------------------------------------------------------
    // page buffer, one entry per byte of a page
    // ------------------------------------------------------------
    // up to sixteen bytes collected, then programmed together
    for (genvar i = 0; i < PAGE_BYTES; i++)
    begin : g_page
        always_ff @(posedge core_clk_i or negedge rstn_i)
        begin
            if (!rstn_i)
            begin
                page_q[i]  <= 8'h00;
                valid_q[i] <= 1'b0;
            end
            // fresh selection or finished programming empties it
            else if ((byte_done && (ph_q == PH_SLV))
                     || ((state_q == ST_PROG) && (prog_cnt_q == PROG_CNT_W'(PROG_CYC - 1))))
            begin
                valid_q[i] <= 1'b0;
            end
            // later bytes overwrite the same slot
            else if (byte_done && (ph_q == PH_DATA) && (addr_q[PAGE_W-1:0] == PAGE_W'(i)))
            begin
                page_q[i]  <= rx_q;
                valid_q[i] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // self-timed programming sequencer
    // ------------------------------------------------------------
    // duration set by PROG_CYC
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            prog_cnt_q <= '0;
        else if (state_q == ST_PROG)
            prog_cnt_q <= prog_cnt_q + PROG_CNT_W'(1);
        else
            prog_cnt_q <= '0;
    end

    // first sixteen cycles copy valid slots into the array
    assign mem_we = (state_q == ST_PROG) && (prog_cnt_q < PROG_CNT_W'(PAGE_BYTES))
                    && valid_q[prog_cnt_q[PAGE_W-1:0]];

    eeps_mem_array u_mem (
        .core_clk_i (core_clk_i),
        .we_i       (mem_we),
        .waddr_i    ({addr_q[ADDR_W-1:PAGE_W], prog_cnt_q[PAGE_W-1:0]}),
        .wdata_i    (page_q[prog_cnt_q[PAGE_W-1:0]]),
        .raddr_i    (addr_q),
        .rdata_o    (mem_rdata)
    );

    // ------------------------------------------------------------
    // transmit shift and open-drain data drive
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_q     <= 8'h00;
            sda_oe_q <= 1'b0;
        end
        else if (start_ev || stop_ev || (state_q == ST_PROG))
            sda_oe_q <= 1'b0;  // never hold the line across a frame edge
        // pull low through the ninth clock
        else if (byte_done)
            sda_oe_q <= (ph_q != PH_SLV) || type_ok;
        // read data changes on falling scl
        else if (load_tx)
        begin
            tx_q     <= mem_rdata;
            sda_oe_q <= ~mem_rdata[7];
        end
        else if ((state_q == ST_TX) && scl_fall)
        begin
            tx_q     <= {tx_q[6:0], 1'b0};
            sda_oe_q <= (cnt_q == BIT_LAST) ? 1'b0 : ~tx_q[6];
        end
        else if (((state_q == ST_ACK) || (state_q == ST_TXACK)) && scl_fall)
            sda_oe_q <= 1'b0;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            busy_q <= 1'b0;
        else
            busy_q <= (state_q == ST_PROG);
    end

    assign sda_o       = 1'b0;  // open drain: only ever pulls low
    assign sda_oe_o    = sda_oe_q;
    assign prog_busy_o = busy_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_start_enter: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        start_ev && (state_q != ST_PROG) |=> (state_q == ST_RX) && (cnt_q == BIT_NONE))
        else $error("start not taken");
    a_stop_idle: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        stop_ev && (state_q != ST_PROG) && (ph_q != PH_DATA) |=> state_q == ST_IDLE)
        else $error("stop did not end frame");
    a_oe_on_fall: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $rose(sda_oe_q) |-> $past(scl_fall))
        else $error("sda pulled outside scl low");
    a_type_reject: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        byte_done && (ph_q == PH_SLV) && !type_ok |=> (state_q == ST_IDLE) && !sda_oe_q)
        else $error("foreign address acknowledged");
    a_ack_held: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        byte_done && type_ok && (ph_q == PH_SLV) |=> sda_oe_q && (state_q == ST_ACK))
        else $error("address not acknowledged");
    a_nack_wait: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_q == ST_TXACK) && scl_fall && !acked_q && !start_ev |=> (state_q == ST_WAIT) && !sda_oe_q)
        else $error("transmit after nack");
    a_prog_silent: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_q == ST_PROG) && $past(state_q == ST_PROG) |-> !sda_oe_q)
        else $error("drive during programming");
    a_prog_starts: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        stop_ev && (state_q != ST_PROG) && (ph_q == PH_DATA) && (|valid_q) |=> state_q == ST_PROG)
        else $error("programming not started");
    a_prog_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_q == ST_PROG) && (prog_cnt_q != PROG_CNT_W'(PROG_CYC - 1)) |=> state_q == ST_PROG)
        else $error("programming cut short");
    a_page_fixed: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        byte_done && (ph_q == PH_DATA) |=> addr_q[ADDR_W-1:PAGE_W] == $past(addr_q[ADDR_W-1:PAGE_W]))
        else $error("page bits moved");
    a_read_incr: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        load_tx |=> addr_q == $past(addr_q) + 11'h001)
        else $error("read address not advanced");

    c_prog: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_q != ST_PROG) ##1 (state_q == ST_PROG));
    c_read_ack: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
        (state_q == ST_TXACK) && scl_fall && acked_q);
    c_page_wrap: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
        byte_done && (ph_q == PH_DATA) && (addr_q[PAGE_W-1:0] == 4'hf));
endmodule

// ---- bench/eeps_bus_master.sv ----
// bus master model driving the two-wire memory slave
// assumes a pull-up resolves the data wire outside this model
`timescale 1ns/100ps
module eeps_bus_master (
    // resolved data wire
    input  wire logic sda_i,
    // clock and data pull-down
    output logic      scl_o,
    output logic      pull_o
);
    // ------------------------------------------------------------
    // idle bus: clock stands high, data released
    // ------------------------------------------------------------
    initial
    begin
        scl_o  = 1'b1;
        pull_o = 1'b0;
    end

    // ------------------------------------------------------------
    // framing, 160 ns phases
    // ------------------------------------------------------------
    // start only from high lines
    task automatic start_c;
        #80 pull_o = 1'b0;
        #160 scl_o = 1'b1;
        #160 pull_o = 1'b1;
        #160 scl_o = 1'b0;
    endtask
    task automatic stop_c;
        #80 pull_o = 1'b1;
        #80 scl_o = 1'b1;
        #160 pull_o = 1'b0;
        #160;
    endtask
    // data moves only while clock low
    task automatic bit_c(input logic b, output logic s);
        #80 pull_o = ~b;
        #80 scl_o = 1'b1;
        #160 s = sda_i;
        scl_o = 1'b0;
    endtask
    // release on ninth clock; extra low time lets the slave let go
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        #80;
        for (int i = 7; i >= 0; i--)
            bit_c(b[i], s);
        bit_c(1'b1, s);
        ack = ~s;
    endtask
    // sampled late in the high phase
    task automatic get_byte(input logic ack, output logic [7:0] b);
        logic s;
        #80;
        for (int i = 7; i >= 0; i--)
            bit_c(1'b1, b[i]);
        bit_c(~ack, s);
    endtask
endmodule

// ---- bench/eeps_slave_tb_top.sv ----
// self-checking bench for the two-wire memory slave
// assumes the master model drives scl and pulls the shared data wire
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module eeps_slave_tb_top;
    import eeps_pkg::*;
    localparam logic [3:0] DEV_T = 4'h6;  // arbitrary type code
    // design pins and resolved wire
    logic       core_clk_i, rstn_i, scl, sda_o, sda_oe_o, prog_busy_o, pull;
    wire        sda = ~pull & ~(sda_oe_o & ~sda_o);
    int         err_count = 0, compares = 0, cyc = 0, nk;
    logic       ack;
    logic [7:0] d;

    eeps_slave #(.PROG_CYC(200), .DEV_TYPE(DEV_T)) dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .prog_busy_o(prog_busy_o));
    eeps_bus_master m_u (.sda_i(sda), .scl_o(scl), .pull_o(pull));

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic bad_type;
        m_u.start_c();
        m_u.put_byte({~DEV_T, 3'h1, 1'b0}, ack);
        `CHK(ack, 1'b0)
        m_u.stop_c();
        $display("bad type done");
    endtask
    // write then poll until the slave answers again
    task automatic wr_page(input logic [10:0] a, input int n, input logic [7:0] d0);
        m_u.start_c();
        m_u.put_byte({DEV_T, a[10:8], 1'b0}, ack);
        `CHK(ack, 1'b1)
        m_u.put_byte(a[7:0], ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++)
        begin
            m_u.put_byte(d0 + 8'(i), ack);
            `CHK(ack, 1'b1)
        end
        m_u.stop_c();
        #200;
        `CHK(prog_busy_o, 1'b1)
        nk = 0;
        do
        begin
            m_u.start_c();
            m_u.put_byte({DEV_T, a[10:8], 1'b0}, ack);
            m_u.stop_c();
            nk += ack ? 0 : 1;
        end while (!ack && nk < 20);
        `CHK(nk > 0, 1'b1)
        `CHK(ack, 1'b1)
        `CHK(prog_busy_o, 1'b0)
        $display("write of %0d bytes done", n);
    endtask
    // reset in the middle of programming; the device must answer at once
    task automatic mid_reset;
        m_u.start_c();
        m_u.put_byte({DEV_T, 3'h5, 1'b0}, ack);
        m_u.put_byte(8'h10, ack);
        m_u.put_byte(8'h5a, ack);
        m_u.stop_c();
        #200;
        `CHK(prog_busy_o, 1'b1)
        rstn_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        `CHK(prog_busy_o, 1'b0)
        `CHK(sda_oe_o, 1'b0)
        rstn_i = 1'b1;
        repeat (3) @(posedge core_clk_i);
        #1;
        m_u.start_c();
        m_u.put_byte({DEV_T, 3'h5, 1'b0}, ack);
        m_u.stop_c();
        `CHK(ack, 1'b1)
        $display("mid reset done");
    endtask
    // read from the counter, last byte refused by the master
    task automatic rd_cur(input int n, input logic [7:0] e0);
        m_u.start_c();
        m_u.put_byte({DEV_T, 3'h0, 1'b1}, ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++)
        begin
            m_u.get_byte(i < n - 1, d);
            `CHK(d, e0 + 8'(i))
        end
        #200;
        `CHK(sda_oe_o, 1'b0)
        m_u.stop_c();
        $display("read of %0d bytes done", n);
    endtask
    task automatic rd_seq(input logic [10:0] a, input int n, input logic [7:0] e0);
        m_u.start_c();
        m_u.put_byte({DEV_T, a[10:8], 1'b0}, ack);
        m_u.put_byte(a[7:0], ack);
        `CHK(ack, 1'b1)
        rd_cur(n, e0);
    endtask

    // ------------------------------------------------------------
    // clock, closing, timeout and main sequence
    // ------------------------------------------------------------
    initial
    begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    task automatic results;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ceiling well above the expected few thousand cycles
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            results();
        end
    end
    initial
    begin
        rstn_i = 1'b0;
        repeat (12) @(posedge core_clk_i);
        #1;
        `CHK(sda_oe_o, 1'b0)
        `CHK(sda_o, 1'b0)
        `CHK(prog_busy_o, 1'b0)
        rstn_i = 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1;
        bad_type();
        mid_reset();
        wr_page(11'h130, 1, 8'h77);
        // eighteen bytes from index e wrap onto e and f
        wr_page(11'h12e, 18, 8'h40);
        rd_seq(11'h120, 16, 8'h42);
        // counter now points past the page
        rd_cur(1, 8'h77);
        results();
    end
endmodule
